// file: rtl/atfc_core.sv
/*
 * Task-file register set and command sequencer of a flash card on an
 * ATA style host port. Host accesses are single-cycle strobes on clk_i.
 * Assumes the host port is already synchronised and decoded to a 4-bit
 * register offset; the flash back end is outside this block.
 */
`timescale 1ns/1ps
module atfc_core
    import atfc_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic true_ide_i,
    input wire logic unit_id_i,
    input wire logic sleep_i,
    input wire logic slave_fail_i,
    input wire logic write_fault_i,
    input wire logic corrected_i,
    input wire logic media_ready_i,
    input wire logic dma_mode_i,
    output logic [15:0] rdata_o,
    output logic intrq_o,
    output logic dma_request_line_o,
    output logic config_int_o,
    output logic write_gate_n_o
);
    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_EXEC = 5'b00010,
        S_RDATA = 5'b00100,
        S_WDATA = 5'b01000,
        S_ERASE = 5'b10000
    } atfc_state_e;

    atfc_state_e state_q;
    logic [7:0] drive_head_q;
    logic [7:0] sect_cnt_q;
    logic [7:0] sect_num_q;
    logic [7:0] cyl_lo_q;
    logic [7:0] cyl_hi_q;
    logic [7:0] error_q;
    logic [7:0] cmd_q;
    logic [7:0] host_control_q;
    logic busy_flag_q;
    logic ready_q;
    logic write_fault_flag_q;
    logic transfer_request_flag_q;
    logic corrected_flag_q;
    logic err_q;
    logic irq_pend_q;
    logic [7:0] word_q;
    logic [2:0] wait_q;
    logic [7:0] rom_addr;
    logic [15:0] rom_data;
    logic soft_reset_bit;
    logic irq_mask_n;
    logic cmd_wr;
    logic data_rd;
    logic data_wr;
    logic is_me;
    logic [7:0] task_status;
    logic [7:0] select_echo;
    logic status_rd;
    logic [7:0] rd_mux;

    atfc_buf_if #(.W(16)) rbuf ();

    assign soft_reset_bit = host_control_q[HC_SRST];
    assign irq_mask_n = host_control_q[HC_MASK];
    // commands refused while busy
    assign cmd_wr = wr_i && addr_i == OFS_STATUS && !busy_flag_q;
    assign data_rd = rd_i && addr_i == OFS_DATA;
    assign data_wr = wr_i && addr_i == OFS_DATA;
    assign status_rd = rd_i && addr_i == OFS_STATUS;
    // addressed unit only; true-IDE mode accepts any command for every unit
    assign is_me = (drive_head_q[DH_UNIT_BIT] == unit_id_i);

    // status image; bit 1 always zero
    assign task_status = {busy_flag_q, ready_q, write_fault_flag_q,
                          ready_q, transfer_request_flag_q,
                          corrected_flag_q, 1'b0, err_q};
    // echo: inverted head, write gate, unit actives
    assign select_echo = {1'b0, write_gate_n_o, ~drive_head_q[3:0],
                          ~(is_me && drive_head_q[DH_UNIT_BIT]),
                          ~(is_me && !drive_head_q[DH_UNIT_BIT])};

    // identify block words; a stalled push re-reads the pending word
    assign rom_addr = (state_q == S_RDATA && !rbuf.in_ready) ?
                      word_q - 8'h01 : word_q;
    atfc_id_rom u_rom (
        .clk_i(clk_i),
        .addr_i(rom_addr),
        .data_o(rom_data)
    );

    // read buffer stalls the sequencer when the host lags
    assign rbuf.in_valid = (state_q == S_RDATA) && !soft_reset_bit;
    assign rbuf.in_data = rom_data;
    assign rbuf.out_ready = data_rd;
    atfc_skid_buf #(.W(16)) u_buf (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .bus(rbuf)
    );

    // read mux
    always_comb
    begin
        unique case (addr_i)
            OFS_DATA: rd_mux = 8'h00;
            OFS_ERROR: rd_mux = error_q;
            OFS_SECT_CNT: rd_mux = sect_cnt_q;
            OFS_SECT_NUM: rd_mux = sect_num_q;
            OFS_CYL_LO: rd_mux = cyl_lo_q;
            OFS_CYL_HI: rd_mux = cyl_hi_q;
            OFS_DRIVE_HEAD: rd_mux = drive_head_q | DH_FIXED_ONES;
            OFS_STATUS: rd_mux = task_status;
            OFS_ALT_STATUS: rd_mux = task_status;
            OFS_ECHO: rd_mux = select_echo;
            default: rd_mux = 8'h00;
        endcase
    end

    // registered read data
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            rdata_o <= 16'h0000;
        end
        else if (data_rd)
        begin
            rdata_o <= rbuf.out_valid ? rbuf.out_data : 16'h0000;
        end
        else if (rd_i)
        begin
            rdata_o <= {8'h00, rd_mux};
        end
    end

    // host control accepted even while busy; spare bits dropped
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            host_control_q <= 8'h00;
        end
        else if (wr_i && addr_i == OFS_ALT_STATUS)
        begin
            host_control_q <= wdata_i[7:0] & 8'h06;
        end
    end

    // parameter registers; mode, unit and head nibble in drive/head
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i || soft_reset_bit)
        begin
            drive_head_q <= 8'h00;
            sect_num_q <= 8'h01;
            cyl_lo_q <= 8'h00;
            cyl_hi_q <= 8'h00;
        end
        else if (wr_i && !busy_flag_q)
        begin
            unique case (addr_i)
                OFS_SECT_NUM: sect_num_q <= wdata_i[7:0];
                OFS_CYL_LO: cyl_lo_q <= wdata_i[7:0];
                OFS_CYL_HI: cyl_hi_q <= wdata_i[7:0];
                OFS_DRIVE_HEAD: drive_head_q <= wdata_i[7:0];
                default: ;
            endcase
        end
    end

    // command sequencer
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i || soft_reset_bit)
        begin
            state_q <= S_IDLE;
            cmd_q <= 8'h00;
            busy_flag_q <= 1'b0;
            ready_q <= 1'b0;
            transfer_request_flag_q <= 1'b0;
            word_q <= 8'h00;
            wait_q <= 3'd0;
            sect_cnt_q <= 8'h01;
            error_q <= DIAG_OK;
            err_q <= 1'b0;
        end
        else
        begin
            if (!busy_flag_q && !ready_q)
            begin
                ready_q <= media_ready_i;
            end
            if (wr_i && addr_i == OFS_SECT_CNT && !busy_flag_q)
            begin
                sect_cnt_q <= wdata_i[7:0];
            end
            unique case (state_q)
                S_IDLE:
                begin
                    if (cmd_wr && (is_me || true_ide_i))
                    begin
                        cmd_q <= wdata_i[7:0];
                        busy_flag_q <= 1'b1;
                        err_q <= 1'b0;
                        error_q <= 8'h00;
                        word_q <= 8'h00;
                        state_q <= S_EXEC;
                    end
                end
                S_EXEC:
                begin
                    if (cmd_q == CMD_POWER_A || cmd_q == CMD_POWER_B)
                    begin
                        sect_cnt_q <= sleep_i ? PWR_SLEEP : PWR_IDLE;
                        busy_flag_q <= 1'b0;
                        state_q <= S_IDLE;
                    end
                    else if (cmd_q == CMD_DIAG)
                    begin
                        error_q <= (true_ide_i && slave_fail_i) ?
                                   DIAG_SLAVE : DIAG_OK;
                        busy_flag_q <= 1'b0;
                        state_q <= S_IDLE;
                    end
                    else if (cmd_q == CMD_ERASE)
                    begin
                        wait_q <= 3'(ERASE_CYCLES);
                        state_q <= S_ERASE;
                    end
                    else if (cmd_q == CMD_FORMAT)
                    begin
                        busy_flag_q <= 1'b0;
                        transfer_request_flag_q <= 1'b1;
                        state_q <= S_WDATA;
                    end
                    else if (cmd_q == CMD_IDENT)
                    begin
                        word_q <= 8'h01; // word 0 requested this cycle
                        state_q <= S_RDATA;
                    end
                    else
                    begin
                        error_q <= ERR_ABORT;
                        err_q <= 1'b1;
                        busy_flag_q <= 1'b0;
                        state_q <= S_IDLE;
                    end
                end
                S_RDATA:
                begin
                    if (rbuf.in_ready)
                    begin
                        busy_flag_q <= 1'b0;
                        transfer_request_flag_q <= 1'b1;
                        word_q <= word_q + 8'h01;
                        if (word_q == 8'h00)
                        begin
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_WDATA:
                begin
                    if (data_wr)
                    begin
                        word_q <= word_q + 8'h01; // data discarded
                        if (word_q == SECTOR_WORDS)
                        begin
                            transfer_request_flag_q <= 1'b0;
                            sect_cnt_q <= 8'h00;
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_ERASE:
                begin
                    wait_q <= wait_q - 3'd1;
                    if (wait_q == 3'd1)
                    begin
                        sect_cnt_q <= sect_cnt_q - 8'h01; // 0 wraps: 256
                        wait_q <= 3'(ERASE_CYCLES);
                        if (sect_cnt_q == 8'h01 || write_fault_i)
                        begin
                            busy_flag_q <= 1'b0;
                            err_q <= write_fault_i;
                            state_q <= S_IDLE;
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
            if (state_q == S_IDLE && transfer_request_flag_q &&
                !rbuf.out_valid)
            begin
                transfer_request_flag_q <= 1'b0;
            end
        end
    end

    // fault and correction flags latch per command; set beats the clear
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i || soft_reset_bit)
        begin
            write_fault_flag_q <= 1'b0;
            corrected_flag_q <= 1'b0;
        end
        else
        begin
            if (write_fault_i && busy_flag_q)
            begin
                write_fault_flag_q <= 1'b1;
            end
            else if (cmd_wr)
            begin
                write_fault_flag_q <= 1'b0;
            end
            if (corrected_i)
            begin
                corrected_flag_q <= 1'b1;
            end
            else if (cmd_wr)
            begin
                corrected_flag_q <= 1'b0;
            end
        end
    end

    // interrupt pending: completion or first identify word push sets, status read clears; set wins
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i || soft_reset_bit)
        begin
            irq_pend_q <= 1'b0;
        end
        else if ((state_q == S_WDATA && data_wr &&
                  word_q == SECTOR_WORDS) ||
                 (state_q == S_EXEC && cmd_q != CMD_ERASE &&
                  cmd_q != CMD_IDENT && cmd_q != CMD_FORMAT) ||
                 (state_q == S_ERASE && wait_q == 3'd1 &&
                  (sect_cnt_q == 8'h01 || write_fault_i)) ||
                 (state_q == S_RDATA && busy_flag_q && rbuf.in_ready))
        begin
            irq_pend_q <= 1'b1;
        end
        else if (status_rd)
        begin
            irq_pend_q <= 1'b0;
        end
    end

    // registered outputs
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            intrq_o <= 1'b0;
            config_int_o <= 1'b0;
            dma_request_line_o <= 1'b0;
            write_gate_n_o <= 1'b1;
        end
        else
        begin
            intrq_o <= irq_pend_q && !irq_mask_n;
            config_int_o <= irq_pend_q && !irq_mask_n;
            dma_request_line_o <= dma_mode_i &&
                (busy_flag_q || transfer_request_flag_q);
            write_gate_n_o <= !(state_q == S_WDATA ||
                                state_q == S_ERASE);
        end
    end

    chk_dma_gated: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        dma_request_line_o |-> $past(busy_flag_q || transfer_request_flag_q))
        else $error("dma request without busy or request");
    chk_drive_ones: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        rd_i && addr_i == OFS_DRIVE_HEAD |=> rdata_o[7] && rdata_o[5])
        else $error("drive/head fixed bits not set");
    chk_status_zero: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        rd_i && addr_i == OFS_STATUS |=> !rdata_o[1])
        else $error("status bit 1 not zero");
    chk_mask_irq: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $past(irq_mask_n) |-> !intrq_o)
        else $error("interrupt while masked");
    chk_power_code: assert property (@(posedge clk_i)
        disable iff (!reset_n_i || soft_reset_bit)
        state_q == S_EXEC && cmd_q == CMD_POWER_A |=>
        sect_cnt_q == ($past(sleep_i) ? PWR_SLEEP : PWR_IDLE) && !busy_flag_q)
        else $error("power check result wrong");
    chk_diag_code: assert property (@(posedge clk_i)
        disable iff (!reset_n_i || soft_reset_bit)
        state_q == S_EXEC && cmd_q == CMD_DIAG && !true_ide_i |=>
        error_q == DIAG_OK)
        else $error("diagnostic code wrong");
    chk_soft_reset: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        soft_reset_bit |=> !busy_flag_q && !ready_q)
        else $error("soft reset not held");
    chk_echo_head: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        rd_i && addr_i == OFS_ECHO |=>
        rdata_o[5:2] == ~$past(drive_head_q[3:0]))
        else $error("echo head bits wrong");
    chk_alt_keeps: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        irq_pend_q && rd_i && addr_i == OFS_ALT_STATUS && !soft_reset_bit
        |=> irq_pend_q)
        else $error("alternate status cleared interrupt");
endmodule : atfc_core

// file: rtl/atfc_pkg.sv
/*
 * Constants for the task-file command core: register offsets, bit
 * positions, command opcodes, diagnostic codes and the last word index of the sector buffer.
 * Assumes the importing module decodes the 4-bit task-file address.
 */
package atfc_pkg;
    // task-file register offsets
    localparam logic [3:0] OFS_DATA = 4'h0;
    localparam logic [3:0] OFS_ERROR = 4'h1;
    localparam logic [3:0] OFS_SECT_CNT = 4'h2;
    localparam logic [3:0] OFS_SECT_NUM = 4'h3;
    localparam logic [3:0] OFS_CYL_LO = 4'h4;
    localparam logic [3:0] OFS_CYL_HI = 4'h5;
    localparam logic [3:0] OFS_DRIVE_HEAD = 4'h6;
    localparam logic [3:0] OFS_STATUS = 4'h7;
    localparam logic [3:0] OFS_ALT_STATUS = 4'hE;
    localparam logic [3:0] OFS_ECHO = 4'hF;
    // drive/head select fields
    localparam int DH_MODE_BIT = 6;
    localparam int DH_UNIT_BIT = 4;
    localparam logic [7:0] DH_FIXED_ONES = 8'hA0;
    // status bit positions
    localparam int ST_BUSY = 7;
    localparam int ST_READY = 6;
    localparam int ST_WFAULT = 5;
    localparam int ST_SEEK = 4;
    localparam int ST_XFER = 3;
    localparam int ST_CORRECTED_FLAG = 2;
    localparam int ST_ERR = 0;
    // host control fields
    localparam int HC_SRST = 2;
    localparam int HC_MASK = 1;
    // opcodes
    localparam logic [7:0] CMD_POWER_A = 8'h98;
    localparam logic [7:0] CMD_POWER_B = 8'hE5;
    localparam logic [7:0] CMD_DIAG = 8'h90;
    localparam logic [7:0] CMD_ERASE = 8'hC0;
    localparam logic [7:0] CMD_FORMAT = 8'h50;
    localparam logic [7:0] CMD_IDENT = 8'hEC;
    // results
    localparam logic [7:0] DIAG_OK = 8'h01;
    localparam logic [7:0] DIAG_SLAVE = 8'h80;
    localparam logic [7:0] PWR_SLEEP = 8'h00;
    localparam logic [7:0] PWR_IDLE = 8'hFF;
    localparam logic [7:0] ERR_ABORT = 8'h04;
    // index of the last word in one 256-word sector buffer
    localparam logic [7:0] SECTOR_WORDS = 8'hFF;
    localparam int ERASE_CYCLES = 4;
endpackage : atfc_pkg

// file: rtl/atfc_buf_if.sv
/*
 * Valid/ready word channel joining the core to its two-entry buffer.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface atfc_buf_if #(parameter int W = 16);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    modport buffer (input in_valid, in_data, out_ready,
                    output in_ready, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready,
                  input in_ready, out_valid, out_data);
endinterface : atfc_buf_if

// file: rtl/atfc_skid_buf.sv
/*
 * Two-entry word buffer with valid and ready on both sides.
 * Assumes synchronous active-low reset on the shared clock.
 */
`timescale 1ns/1ps
module atfc_skid_buf
    import atfc_pkg::*;
#(
    parameter int W = 16
)(
    input wire logic clk_i,
    input wire logic reset_n_i,
    atfc_buf_if.buffer bus
);
    logic [W-1:0] mem_q [2];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] count_q;
    logic push;
    logic pop;

    // handshakes on each side
    assign bus.in_ready = (count_q != 2'd2);
    assign bus.out_valid = (count_q != 2'd0);
    assign bus.out_data = mem_q[rd_ptr_q];
    assign push = bus.in_valid && bus.in_ready;
    assign pop = bus.out_valid && bus.out_ready;

    // storage
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= bus.in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'd0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop)
            begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : atfc_skid_buf

// file: rtl/atfc_id_rom.sv
/*
 * Identify-device parameter block, 256 words, registered read port.
 * Assumes a word index presented one cycle before the data is used.
 */
`timescale 1ns/1ps
module atfc_id_rom
    import atfc_pkg::*;
#(
    parameter logic [15:0] CYLS = 16'h03E8,
    parameter logic [15:0] HEADS = 16'h0010,
    parameter logic [15:0] SPT = 16'h003F
)(
    input wire logic clk_i,
    input wire logic [7:0] addr_i,
    output logic [15:0] data_o
);
    logic [15:0] word;
    logic [31:0] cap;

    assign cap = 32'(CYLS) * 32'(HEADS) * 32'(SPT);

    // reserved words are zero
    always_comb
    begin
        unique case (addr_i)
            8'd0: word = 16'h045A;
            8'd1: word = CYLS;
            8'd3: word = HEADS;
            8'd6: word = SPT;
            8'd7: word = cap[31:16];
            8'd8: word = cap[15:0];
            8'd49: word = 16'h0F00;
            8'd54: word = CYLS;
            8'd55: word = HEADS;
            8'd56: word = SPT;
            8'd57: word = cap[15:0];
            8'd58: word = cap[31:16];
            8'd60: word = cap[15:0];
            8'd61: word = cap[31:16];
            default: word = 16'h0000;
        endcase
    end

    // registered read
    always_ff @(posedge clk_i)
    begin
        data_o <= word;
    end
endmodule : atfc_id_rom

// file: tb/atfc_host_model.sv
/*
 * Host controller model: single-cycle read and write strobes.
 * Assumes the core samples strobes on the rising edge of clk_i.
 */
`timescale 1ns/1ps
module atfc_host_model (
    input wire logic clk_i,
    input wire logic [15:0] rdata_i,
    output logic rd_o,
    output logic wr_o,
    output logic [3:0] addr_o,
    output logic [15:0] wdata_o
);
    // idle bus at time zero
    initial
    begin
        rd_o = 1'b0;
        wr_o = 1'b0;
        addr_o = 4'h0;
        wdata_o = 16'h0000;
    end

    // one write strobe, then the data lines are released to a toggled value
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask : wr

    // one read strobe; data is taken once the answer edge has settled
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_i);
        rd_o <= 1'b1;
        addr_o <= a;
        @(posedge clk_i);
        rd_o <= 1'b0;
        @(posedge clk_i);
        #1 d = rdata_i;
    endtask : rd
endmodule : atfc_host_model

// file: tb/atfc_core_tb.sv
/*
 * Self-checking bench for the task-file command core.
 * Assumes the host model for all register traffic.
 */
`timescale 1ns/1ps
module atfc_core_tb
    import atfc_pkg::*;
;
    logic clk_i, reset_n_i, rd_i, wr_i, intrq_o, config_int_o;
    logic dma_request_line_o, write_gate_n_o, gate_low = 1'b0;
    logic [3:0] addr_i;
    logic [15:0] wdata_i, rdata_o;
    logic true_ide_i, sleep_i, slave_fail_i, write_fault_i, media_ready_i;
    logic dma_mode_i, corrected_i;
    int fail_count = 0;
    int compares = 0;

    atfc_core i_atfc_core (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .rd_i(rd_i), .wr_i(wr_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .true_ide_i(true_ide_i), .unit_id_i(1'b0), .sleep_i(sleep_i),
        .slave_fail_i(slave_fail_i), .write_fault_i(write_fault_i),
        .corrected_i(corrected_i), .media_ready_i(media_ready_i),
        .dma_mode_i(dma_mode_i), .rdata_o(rdata_o), .intrq_o(intrq_o),
        .dma_request_line_o(dma_request_line_o),
        .config_int_o(config_int_o), .write_gate_n_o(write_gate_n_o));
    atfc_host_model i_atfc_host_model (.clk_i(clk_i), .rdata_i(rdata_o),
        .rd_o(rd_i), .wr_o(wr_i), .addr_o(addr_i), .wdata_o(wdata_i));

    // 100 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // remembers any cycle with the write gate asserted
    always @(posedge clk_i)
        if (write_gate_n_o === 1'b0)
            gate_low <= 1'b1;

    task automatic chk(input string n, input logic [7:0] seen, exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    task automatic rdc(input logic [3:0] a, input logic [7:0] m, e);
        logic [15:0] v;
        i_atfc_host_model.rd(a, v);
        chk($sformatf("reg %h", a), v[7:0] & m, e);
    endtask : rdc

    task automatic cmd(input logic [7:0] op);
        i_atfc_host_model.wr(OFS_STATUS, {8'h00, op});
    endtask : cmd

    task automatic wait_irq();
        for (int i = 0; i < 2000 && intrq_o !== 1'b1; i++)
            @(posedge clk_i);
        chk("intrq", {7'h00, intrq_o}, 8'h01);
    endtask : wait_irq

    task automatic wait_drq();
        logic [15:0] v = 16'h0000;
        for (int i = 0; i < 50 && v[ST_XFER] !== 1'b1; i++)
            i_atfc_host_model.rd(OFS_ALT_STATUS, v);
        chk("drq", {7'h00, v[ST_XFER]}, 8'h01);
    endtask : wait_drq

    task automatic final_report();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    // watchdog against a hung handshake
    initial
    begin
        #200000;
        fail_count++;
        final_report();
    end

    // test sequence
    initial
    begin
        logic [15:0] d;
        reset_n_i = 1'b0;
        {true_ide_i, sleep_i, slave_fail_i} = 3'b000;
        {write_fault_i, media_ready_i, dma_mode_i, corrected_i} = 4'h0;
        repeat (8) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rdc(OFS_ALT_STATUS, 8'h42, 8'h00);
        @(posedge clk_i);
        media_ready_i <= 1'b1;
        rdc(OFS_STATUS, 8'hC2, 8'h40);
        i_atfc_host_model.wr(OFS_DRIVE_HEAD, 16'h000B);
        rdc(OFS_DRIVE_HEAD, 8'hFF, 8'hAB);
        rdc(OFS_ECHO, 8'h7F, 8'h52);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk_i);
            sleep_i <= i[0];
            cmd(i[1] ? CMD_POWER_B : CMD_POWER_A);
            wait_irq();
            chk("cfg int", {7'h00, config_int_o}, 8'h01);
            rdc(OFS_ALT_STATUS, 8'h80, 8'h00);
            chk("intrq kept", {7'h00, intrq_o}, 8'h01);
            rdc(OFS_SECT_CNT, 8'hFF, i[0] ? PWR_SLEEP : PWR_IDLE);
            rdc(OFS_STATUS, 8'h80, 8'h00);
            repeat (2) @(posedge clk_i);
            chk("intrq clear", {7'h00, intrq_o}, 8'h00);
        end
        i_atfc_host_model.wr(OFS_ALT_STATUS, 16'h00FA);
        cmd(CMD_POWER_A);
        repeat (20) @(posedge clk_i);
        chk("intrq masked", {7'h00, intrq_o}, 8'h00);
        chk("cfg masked", {7'h00, config_int_o}, 8'h00);
        rdc(OFS_STATUS, 8'h81, 8'h00);
        i_atfc_host_model.wr(OFS_ALT_STATUS, 16'h0000);
        cmd(8'h00);
        wait_irq();
        rdc(OFS_ERROR, 8'hFF, ERR_ABORT);
        rdc(OFS_STATUS, 8'h01, 8'h01);
        cmd(CMD_DIAG);
        wait_irq();
        rdc(OFS_ERROR, 8'hFF, DIAG_OK);
        rdc(OFS_STATUS, 8'h81, 8'h00);
        @(posedge clk_i);
        {true_ide_i, slave_fail_i} <= 2'b11;
        i_atfc_host_model.wr(OFS_DRIVE_HEAD, 16'h001B);
        cmd(CMD_DIAG);
        wait_irq();
        rdc(OFS_ERROR, 8'hF0, DIAG_SLAVE);
        rdc(OFS_STATUS, 8'h81, 8'h00);
        @(posedge clk_i);
        {true_ide_i, slave_fail_i} <= 2'b00;
        i_atfc_host_model.wr(OFS_DRIVE_HEAD, 16'h000B);
        i_atfc_host_model.wr(OFS_SECT_CNT, 16'h0002);
        cmd(CMD_ERASE);
        rdc(OFS_ALT_STATUS, 8'h80, 8'h80);
        wait_irq();
        chk("gate", {7'h00, gate_low}, 8'h01);
        rdc(OFS_SECT_CNT, 8'hFF, 8'h00);
        rdc(OFS_STATUS, 8'h29, 8'h00);
        i_atfc_host_model.wr(OFS_SECT_CNT, 16'h0000);
        cmd(CMD_ERASE);
        repeat (600) @(posedge clk_i);
        rdc(OFS_ALT_STATUS, 8'h80, 8'h80);
        wait_irq();
        rdc(OFS_STATUS, 8'h21, 8'h00);
        @(posedge clk_i);
        write_fault_i <= 1'b1;
        i_atfc_host_model.wr(OFS_SECT_CNT, 16'h0001);
        cmd(CMD_ERASE);
        wait_irq();
        rdc(OFS_STATUS, 8'h21, 8'h21);
        @(posedge clk_i);
        write_fault_i <= 1'b0;
        cmd(CMD_FORMAT);
        wait_drq();
        for (int i = 0; i < 256; i++)
            i_atfc_host_model.wr(OFS_DATA, 16'(i));
        wait_irq();
        rdc(OFS_STATUS, 8'h09, 8'h00);
        @(posedge clk_i);
        {dma_mode_i, corrected_i} <= 2'b11;
        cmd(CMD_IDENT);
        wait_drq();
        chk("dma", {7'h00, dma_request_line_o}, 8'h01);
        for (int i = 0; i < 256; i++)
        begin
            i_atfc_host_model.rd(OFS_DATA, d);
            if (i == 0 || i == 69)
                chk("id hi", d[15:8], i ? 8'h00 : 8'h04);
            if (i == 0 || i == 69)
                chk("id lo", d[7:0], i ? 8'h00 : 8'h5A);
            if (i == 3)
                chk("id heads", d[7:0], 8'h10);
        end
        rdc(OFS_ALT_STATUS, 8'h0D, 8'h04);
        chk("dma idle", {7'h00, dma_request_line_o}, 8'h00);
        i_atfc_host_model.wr(OFS_ALT_STATUS, 16'h0004);
        rdc(OFS_ALT_STATUS, 8'h40, 8'h00);
        i_atfc_host_model.wr(OFS_ALT_STATUS, 16'h0000);
        repeat (4) @(posedge clk_i);
        rdc(OFS_ALT_STATUS, 8'hC0, 8'h40);
        final_report();
    end
endmodule : atfc_core_tb
